// ==== include/ssp_pkg.sv ====
// Constants, field positions and the frame phase type of the sensor serial slave port.
// Assumes every file that uses it compiles after it.
package ssp_pkg;
  // Frame layout
  localparam int         SSP_BYTE_W    = 8;
  localparam int         SSP_ADDR_W    = 6;
  localparam int         SSP_RW_POS    = 7;
  localparam int         SSP_AI_POS    = 6;
  localparam logic [2:0] SSP_BIT_FIRST = 3'h0;
  localparam logic [2:0] SSP_BIT_LAST  = 3'h7;
  localparam logic [2:0] SSP_BIT_STEP  = 3'h1;

  // Format register and its wire-count bit
  localparam logic [5:0] SSP_FORMAT_ADDR = 6'h31;
  localparam int         SSP_WIRE_POS    = 6;
  localparam logic       SSP_WIRE_RESET  = 1'h0;

  // Lanes of the core-side synchroniser
  localparam int         SSP_SY_W    = 5;
  localparam int         SSP_SY_CS   = 0;
  localparam int         SSP_SY_SCLK = 1;
  localparam int         SSP_SY_SDI  = 2;
  localparam int         SSP_SY_WR   = 3;
  localparam int         SSP_SY_RD   = 4;
  localparam logic [4:0] SSP_SY_RST  = 5'h07;

  // Position inside a frame
  typedef enum logic {
    SSP_PH_HDR  = 1'b0,
    SSP_PH_DATA = 1'b1
  } ssp_phase_t;
endpackage

// ==== design/ssp_sync.sv ====
// Three-flop input synchroniser with agreement filter, one lane per bit.
// Assumes inputs are asynchronous to core_clk; reset is synchronous, active high.
module ssp_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // Lanes
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] nxt_out;

  if (WIDTH < 1) begin : g_chk
    $error("ssp_sync needs at least one lane");
  end

  // A lane changes only once the second and third stages agree
  always_comb begin
    nxt_out = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & out_ff);
  end

  // Stage registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_ff  <= RST_VAL;
      s2_ff  <= RST_VAL;
      s3_ff  <= RST_VAL;
      out_ff <= RST_VAL;
    end else begin
      s1_ff  <= async_in;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign sync_out = out_ff;
endmodule

// ==== design/ssp_serial_port.sv ====
// Slave serial port: SPI mode 3 framing, register access hand-off and I2C mode detection.
// Assumes an external master drives select, clock and data; user logic answers reads in the same cycle.
module ssp_serial_port
  import ssp_pkg::*;
#(
  parameter int ADDR_W = ssp_pkg::SSP_ADDR_W
) (
  // Core clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            reset,
  // Serial pins
  input  wire logic                            spi_sclk,
  input  wire logic                            spi_cs_n,
  input  wire logic                            spi_sdi_in,
  output logic                                 spi_sdo_out,
  output logic                                 spi_sdo_oe,
  output logic                                 spi_sdio_out,
  output logic                                 spi_sdio_oe,
  // Register write hand-off
  output logic                                 reg_wr_en,
  output logic      [ADDR_W-1:0]               reg_wr_addr,
  output logic      [ssp_pkg::SSP_BYTE_W-1:0]  reg_wr_data,
  // Register read hand-off
  output logic                                 reg_rd_en,
  output logic      [ADDR_W-1:0]               reg_rd_addr,
  input  wire logic [ssp_pkg::SSP_BYTE_W-1:0]  reg_rd_data,
  // Status
  output logic                                 cfg_three_wire,
  output logic                                 i2c_mode,
  output logic                                 i2c_start,
  output logic                                 i2c_stop
);
  import ssp_pkg::*;

  localparam logic [ADDR_W-1:0] ADDR_ONE = ADDR_W'(1);

  if (ADDR_W < SSP_ADDR_W || ADDR_W > SSP_BYTE_W - 2) begin : g_chk
    $error("ADDR_W must fit the first byte and hold the format register address");
  end

  // Frame state on the serial clock, cleared by select high
  logic [2:0]            bit_cnt_ff;
  logic [2:0]            nxt_bit_cnt;
  ssp_phase_t            phase_ff;
  ssp_phase_t            nxt_phase;
  logic                  is_read_ff;
  logic                  nxt_is_read;
  logic                  auto_increment_flag_ff;
  logic                  nxt_auto_increment_flag;
  logic [ADDR_W-1:0]     addr_ff;
  logic [ADDR_W-1:0]     nxt_addr;
  logic [SSP_BYTE_W-1:0] shin_ff;
  logic [SSP_BYTE_W-1:0] shin_w;
  logic                  byte_done;
  logic [ADDR_W-1:0]     addr_inc;

  // Words handed to the core, cleared only by reset
  logic                  wr_tgl_ff;
  logic                  nxt_wr_tgl;
  logic [ADDR_W-1:0]     lk_wr_addr_ff;
  logic [ADDR_W-1:0]     nxt_lk_wr_addr;
  logic [SSP_BYTE_W-1:0] lk_wr_data_ff;
  logic [SSP_BYTE_W-1:0] nxt_lk_wr_data;
  logic                  rd_tgl_ff;
  logic                  nxt_rd_tgl;
  logic [ADDR_W-1:0]     lk_rd_addr_ff;
  logic [ADDR_W-1:0]     nxt_lk_rd_addr;

  // Falling-edge output state
  logic [SSP_BYTE_W-1:0] out_sh_ff;
  logic [SSP_BYTE_W-1:0] nxt_out_sh;
  logic                  drive_ff;
  logic                  nxt_drive;
  logic                  tw1_ff;
  logic                  tw2_ff;

  // Core side
  logic [SSP_SY_W-1:0]   sy;
  logic                  wr_seen_ff;
  logic                  rd_seen_ff;
  logic                  wr_en_ff;
  logic [ADDR_W-1:0]     wr_addr_ff;
  logic [SSP_BYTE_W-1:0] wr_data_ff;
  logic                  rd_en_ff;
  logic [ADDR_W-1:0]     rd_addr_ff;
  logic [SSP_BYTE_W-1:0] rd_data_ff;
  logic                  three_wire_ff;
  logic                  sda_prev_ff;
  logic                  start_ff;
  logic                  stop_ff;
  logic                  nxt_wr_en;
  logic [ADDR_W-1:0]     nxt_wr_addr;
  logic [SSP_BYTE_W-1:0] nxt_wr_data;
  logic                  nxt_rd_en;
  logic [ADDR_W-1:0]     nxt_rd_addr;
  logic [SSP_BYTE_W-1:0] nxt_rd_data;
  logic                  nxt_three_wire;
  logic                  nxt_start;
  logic                  nxt_stop;

  // Rising-edge shift, header decode and pointer advance
  always_comb begin
    shin_w                  = {shin_ff[SSP_BYTE_W-2:0], spi_sdi_in};
    byte_done               = (bit_cnt_ff == SSP_BIT_LAST);
    addr_inc                = addr_ff + ADDR_ONE;
    nxt_bit_cnt             = bit_cnt_ff + SSP_BIT_STEP;
    nxt_phase               = phase_ff;
    nxt_is_read             = is_read_ff;
    nxt_auto_increment_flag = auto_increment_flag_ff;
    nxt_addr                = addr_ff;
    if (byte_done) begin
      if (phase_ff == SSP_PH_HDR) begin
        nxt_phase               = SSP_PH_DATA;
        nxt_is_read             = shin_w[SSP_RW_POS];
        nxt_auto_increment_flag = shin_w[SSP_AI_POS];
        nxt_addr                = shin_w[ADDR_W-1:0];
      end else if (auto_increment_flag_ff) begin
        nxt_addr = addr_inc;
      end
    end
  end

  // Frame registers; select high ends the frame without a clock edge
  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_cnt_ff             <= SSP_BIT_FIRST;
      phase_ff               <= SSP_PH_HDR;
      is_read_ff             <= 1'b0;
      auto_increment_flag_ff <= 1'b0;
      addr_ff                <= '0;
      shin_ff                <= '0;
    end else begin
      bit_cnt_ff             <= nxt_bit_cnt;
      phase_ff               <= nxt_phase;
      is_read_ff             <= nxt_is_read;
      auto_increment_flag_ff <= nxt_auto_increment_flag;
      addr_ff                <= nxt_addr;
      shin_ff                <= shin_w;
    end
  end

  // Byte hand-off: words change together with their toggle and then stand still
  always_comb begin
    nxt_wr_tgl     = wr_tgl_ff;
    nxt_lk_wr_addr = lk_wr_addr_ff;
    nxt_lk_wr_data = lk_wr_data_ff;
    nxt_rd_tgl     = rd_tgl_ff;
    nxt_lk_rd_addr = lk_rd_addr_ff;
    if (byte_done) begin
      if (phase_ff == SSP_PH_HDR) begin
        if (shin_w[SSP_RW_POS]) begin
          nxt_lk_rd_addr = shin_w[ADDR_W-1:0];
          nxt_rd_tgl     = ~rd_tgl_ff;
        end
      end else if (!is_read_ff) begin
        nxt_lk_wr_addr = addr_ff;
        nxt_lk_wr_data = shin_w;
        nxt_wr_tgl     = ~wr_tgl_ff;
      end else begin
        nxt_lk_rd_addr = auto_increment_flag_ff ? addr_inc : addr_ff;
        nxt_rd_tgl     = ~rd_tgl_ff;
      end
    end
  end

  // Hand-off registers
  always_ff @(posedge spi_sclk or posedge reset) begin
    if (reset) begin
      wr_tgl_ff     <= 1'b0;
      lk_wr_addr_ff <= '0;
      lk_wr_data_ff <= '0;
      rd_tgl_ff     <= 1'b0;
      lk_rd_addr_ff <= '0;
    end else begin
      wr_tgl_ff     <= nxt_wr_tgl;
      lk_wr_addr_ff <= nxt_lk_wr_addr;
      lk_wr_data_ff <= nxt_lk_wr_data;
      rd_tgl_ff     <= nxt_rd_tgl;
      lk_rd_addr_ff <= nxt_lk_rd_addr;
    end
  end

  // Falling-edge shift out; the fetched byte is loaded as each read byte begins
  always_comb begin
    nxt_out_sh = {out_sh_ff[SSP_BYTE_W-2:0], 1'b0};
    nxt_drive  = drive_ff;
    if (bit_cnt_ff == SSP_BIT_FIRST && phase_ff == SSP_PH_DATA && is_read_ff) begin
      nxt_out_sh = rd_data_ff;
      nxt_drive  = 1'b1;
    end
  end

  // Output registers, released at once by select high
  always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      out_sh_ff <= '0;
      drive_ff  <= 1'b0;
    end else begin
      out_sh_ff <= nxt_out_sh;
      drive_ff  <= nxt_drive;
    end
  end

  // Wire-count bit brought onto the serial clock
  always_ff @(negedge spi_sclk or posedge reset) begin
    if (reset) begin
      tw1_ff <= SSP_WIRE_RESET;
      tw2_ff <= SSP_WIRE_RESET;
    end else begin
      tw1_ff <= three_wire_ff;
      tw2_ff <= tw1_ff;
    end
  end

  // Pin drivers; enables gated by select so release needs no clock
  assign spi_sdo_out  = out_sh_ff[SSP_BYTE_W-1];
  assign spi_sdio_out = out_sh_ff[SSP_BYTE_W-1];
  assign spi_sdo_oe   = drive_ff & ~spi_cs_n & ~tw2_ff;
  assign spi_sdio_oe  = drive_ff & ~spi_cs_n & tw2_ff;

  // Pins and toggles into the core domain
  ssp_sync #(
    .WIDTH   (SSP_SY_W),
    .RST_VAL (SSP_SY_RST)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in ({rd_tgl_ff, wr_tgl_ff, spi_sdi_in, spi_sclk, spi_cs_n}),
    .sync_out (sy)
  );

  // Core hand-off, format bit snoop and I2C bus conditions
  always_comb begin
    nxt_wr_en      = sy[SSP_SY_WR] ^ wr_seen_ff;
    nxt_wr_addr    = nxt_wr_en ? lk_wr_addr_ff : wr_addr_ff;
    nxt_wr_data    = nxt_wr_en ? lk_wr_data_ff : wr_data_ff;
    nxt_rd_en      = sy[SSP_SY_RD] ^ rd_seen_ff;
    nxt_rd_addr    = nxt_rd_en ? lk_rd_addr_ff : rd_addr_ff;
    nxt_rd_data    = rd_en_ff ? reg_rd_data : rd_data_ff;
    nxt_three_wire = three_wire_ff;
    if (wr_en_ff && wr_addr_ff == ADDR_W'(SSP_FORMAT_ADDR)) begin
      nxt_three_wire = wr_data_ff[SSP_WIRE_POS];
    end
    nxt_start = sy[SSP_SY_CS] & sy[SSP_SY_SCLK] & sda_prev_ff & ~sy[SSP_SY_SDI];
    nxt_stop  = sy[SSP_SY_CS] & sy[SSP_SY_SCLK] & ~sda_prev_ff & sy[SSP_SY_SDI];
  end

  // Core registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_seen_ff    <= 1'b0;
      rd_seen_ff    <= 1'b0;
      wr_en_ff      <= 1'b0;
      wr_addr_ff    <= '0;
      wr_data_ff    <= '0;
      rd_en_ff      <= 1'b0;
      rd_addr_ff    <= '0;
      rd_data_ff    <= '0;
      three_wire_ff <= SSP_WIRE_RESET;
      sda_prev_ff   <= 1'b1;
      start_ff      <= 1'b0;
      stop_ff       <= 1'b0;
    end else begin
      wr_seen_ff    <= sy[SSP_SY_WR];
      rd_seen_ff    <= sy[SSP_SY_RD];
      wr_en_ff      <= nxt_wr_en;
      wr_addr_ff    <= nxt_wr_addr;
      wr_data_ff    <= nxt_wr_data;
      rd_en_ff      <= nxt_rd_en;
      rd_addr_ff    <= nxt_rd_addr;
      rd_data_ff    <= nxt_rd_data;
      three_wire_ff <= nxt_three_wire;
      sda_prev_ff   <= sy[SSP_SY_SDI];
      start_ff      <= nxt_start;
      stop_ff       <= nxt_stop;
    end
  end

  // Core outputs
  assign reg_wr_en      = wr_en_ff;
  assign reg_wr_addr    = wr_addr_ff;
  assign reg_wr_data    = wr_data_ff;
  assign reg_rd_en      = rd_en_ff;
  assign reg_rd_addr    = rd_addr_ff;
  assign cfg_three_wire = three_wire_ff;
  assign i2c_mode       = sy[SSP_SY_CS];
  assign i2c_start      = start_ff;
  assign i2c_stop       = stop_ff;
endmodule

// ==== sim/ssp_port_assertions.sv ====
// Checker for the serial slave port: pin enables, register hand-off, mode status.
// Assumes a bind onto ssp_serial_port; every check runs on core_clk.
module ssp_port_assertions
  import ssp_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              reset,
  // Serial pins
  input wire logic              spi_cs_n,
  input wire logic              spi_sdo_oe,
  input wire logic              spi_sdio_oe,
  // Hand-off and status
  input wire logic              reg_wr_en,
  input wire logic [ADDR_W-1:0] reg_wr_addr,
  input wire logic [7:0]        reg_wr_data,
  input wire logic              reg_rd_en,
  input wire logic              cfg_three_wire,
  input wire logic              i2c_mode,
  input wire logic              i2c_start,
  input wire logic              i2c_stop
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Output enables follow select and the chosen wiring
  oe_release_a: assert property (spi_cs_n |-> !spi_sdo_oe && !spi_sdio_oe)
    else $error("data output driven while deselected");
  oe_single_a: assert property (!(spi_sdo_oe && spi_sdio_oe))
    else $error("both data outputs driven");
  four_wire_a: assert property (spi_sdo_oe |-> !cfg_three_wire)
    else $error("dedicated output used in three-wire setup");
  shared_line_a: assert property (spi_sdio_oe |-> cfg_three_wire)
    else $error("shared line driven in four-wire setup");
  write_quiet_a: assert property (reg_wr_en |-> !spi_sdo_oe && !spi_sdio_oe)
    else $error("output driven during a write");
  // Hand-off strobes and wiring bit
  wr_pulse_a: assert property (reg_wr_en |=> !reg_wr_en)
    else $error("write strobe longer than one cycle");
  rd_pulse_a: assert property (reg_rd_en |=> !reg_rd_en)
    else $error("read strobe longer than one cycle");
  wire_cfg_a: assert property (reg_wr_en && reg_wr_addr == SSP_FORMAT_ADDR |->
    ##[0:2] cfg_three_wire == reg_wr_data[SSP_WIRE_POS]) else $error("wiring bit not taken");
  // Mode selection by the select level
  i2c_sel_a: assert property (spi_cs_n [*8] |-> i2c_mode)
    else $error("select high but not in I2C mode");
  spi_sel_a: assert property (!spi_cs_n [*8] |-> !i2c_mode)
    else $error("select low but still in I2C mode");
  i2c_cond_a: assert property (i2c_start || i2c_stop |-> i2c_mode)
    else $error("I2C condition seen outside I2C mode");

  // Main scenarios reached
  rd_seen_c: cover property (reg_rd_en);
  sdio_seen_c: cover property (spi_sdio_oe);
  start_seen_c: cover property (i2c_start);
endmodule

// ==== sim/ssp_spi_master.sv ====
// Behavioural SPI master, mode 3 at 5 MHz, four or three wires.
// Assumes the bench calls xfer for one frame at a time.
module ssp_spi_master (
  // Pins the master drives
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output wire logic spi_sdi_in,
  // Port outputs
  input  wire logic spi_sdo_out,
  input  wire logic spi_sdo_oe,
  input  wire logic spi_sdio_out,
  input  wire logic spi_sdio_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv;
  logic rel;

  // Shared line: port wins when enabled, a released master leaves the inverse
  assign spi_sdi_in = spi_sdio_oe ? spi_sdio_out : (rel ? ~drv : drv);

  // Idle: deselected, clock high, data driven
  initial begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    drv = 1'b1;
    rel = 1'b0;
  end

  // One frame: header then n bytes MSB first; read bits taken at rising edges
  task automatic xfer(input logic [7:0] hdr, input logic three, input int n, inout logic [7:0] dat [8]);
    logic [7:0] sh;
    #1.3 spi_cs_n = 1'b0;
    for (int b = 0; b <= n; b++) begin
      sh = (b == 0) ? hdr : (hdr[7] ? 8'hff : dat[b-1]);
      for (int i = 7; i >= 0; i--) begin
        #100 spi_sclk = 1'b0;
        drv = sh[i];
        rel = hdr[7] & three & (b > 0);
        #100 spi_sclk = 1'b1;
        if (hdr[7] && b > 0) begin
          dat[b-1][i] = three ? (spi_sdio_oe ? spi_sdio_out : 1'bz) : (spi_sdo_oe ? spi_sdo_out : 1'bz);
        end
      end
    end
    #100 spi_cs_n = 1'b1;
    rel = 1'b0;
    drv = 1'b1;
    #200;
  endtask
endmodule

// ==== sim/test_sensor_serial_slave_port.sv ====
// Self-checking bench: a master model sends frames, a byte array answers reads.
// Assumes ssp_pkg compiled first; core clock 4 ns, serial clock 200 ns.
module test_sensor_serial_slave_port
  import ssp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, reset, spi_sclk, spi_cs_n, spi_sdi_in, three;
  logic        spi_sdo_out, spi_sdo_oe, spi_sdio_out, spi_sdio_oe;
  logic        reg_wr_en, reg_rd_en, cfg_three_wire, i2c_mode, i2c_start, i2c_stop;
  logic [5:0]  reg_wr_addr, reg_rd_addr;
  logic [7:0]  reg_wr_data, reg_rd_data;
  logic [7:0]  mem [64];
  logic [7:0]  dat [8];
  logic [13:0] wq [$];
  int          fails, comparisons, starts, stops, cyc;

  ssp_serial_port uut (
    .core_clk(core_clk), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi_in(spi_sdi_in),
    .spi_sdo_out(spi_sdo_out), .spi_sdo_oe(spi_sdo_oe), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe(spi_sdio_oe),
    .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .cfg_three_wire(cfg_three_wire),
    .i2c_mode(i2c_mode), .i2c_start(i2c_start), .i2c_stop(i2c_stop)
  );
  ssp_spi_master m (
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi_in(spi_sdi_in), .spi_sdo_out(spi_sdo_out),
    .spi_sdo_oe(spi_sdo_oe), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe(spi_sdio_oe)
  );

  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // User side: answer reads at the falling edge
  always @(negedge core_clk) begin
    reg_rd_data <= mem[reg_rd_addr];
  end

  // Log writes and I2C pulses; cut a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (reg_wr_en === 1'b1) wq.push_back({reg_wr_addr, reg_wr_data});
    starts += int'(i2c_start === 1'b1);
    stops += int'(i2c_stop === 1'b1);
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_byte({7'h0, got}, {7'h0, exp});
  endtask

  // One frame, then compare logged writes or returned bytes
  task automatic frame(input logic [7:0] hdr, input int n);
    logic [5:0] a;
    wq.delete();
    m.xfer(hdr, three, n, dat);
    if (!hdr[7]) check_byte(8'(wq.size()), 8'(n));
    for (int k = 0; k < n; k++) begin
      a = hdr[5:0] + (hdr[6] ? 6'(k) : 6'h0);
      if (hdr[7]) begin
        check_byte(dat[k], mem[a]);
      end else begin
        check_byte({2'h0, wq[k][13:8]}, {2'h0, a});
        check_byte(wq[k][7:0], dat[k]);
      end
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Test sequence
  initial begin
    reset = 1'b1;
    reg_rd_data = 8'h00;
    three = 1'b0;
    for (int i = 0; i < 64; i++) mem[i] = 8'(i * 37 + 11);
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    repeat (8) @(negedge core_clk);
    check_bit(i2c_mode, 1'b1);
    dat[0] = 8'ha5;
    dat[1] = 8'h3c;
    dat[2] = 8'h81;
    frame(8'h05, 2);
    frame(8'h7f, 3);
    $display("four-wire write test done");
    frame(8'hd0, 3);
    frame(8'h8a, 2);
    $display("four-wire read test done");
    dat[0] = 8'(1 << SSP_WIRE_POS);
    frame({2'h0, SSP_FORMAT_ADDR}, 1);
    check_bit(cfg_three_wire, 1'b1);
    three = 1'b1;
    frame(8'hfe, 3);
    dat[0] = 8'h00;
    frame({2'h0, SSP_FORMAT_ADDR}, 1);
    check_bit(cfg_three_wire, 1'b0);
    three = 1'b0;
    frame(8'hc1, 1);
    $display("three-wire test done");
    m.spi_cs_n = 1'b0;
    repeat (12) @(negedge core_clk);
    check_bit(i2c_mode, 1'b0);
    m.spi_cs_n = 1'b1;
    repeat (12) @(negedge core_clk);
    starts = 0;
    stops = 0;
    m.drv = 1'b0;
    repeat (12) @(negedge core_clk);
    m.drv = 1'b1;
    repeat (12) @(negedge core_clk);
    check_bit(i2c_mode, 1'b1);
    check_byte(8'(starts), 8'h01);
    check_byte(8'(stops), 8'h01);
    $display("mode select test done");
    close_out();
  end
endmodule

bind ssp_serial_port ssp_port_assertions #(.ADDR_W(ADDR_W)) chk (
  .core_clk(core_clk), .reset(reset), .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe),
  .spi_sdio_oe(spi_sdio_oe), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
  .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .cfg_three_wire(cfg_three_wire),
  .i2c_mode(i2c_mode), .i2c_start(i2c_start), .i2c_stop(i2c_stop)
);
